/* File: hdl/sram_qualify_pkg.sv */
// Purpose: shared constants for the sram cycle qualify and sleep block
// Assumes: single clock at 25 MHz
// Notes:   interval counts are whole clock cycles
package sram_qualify_pkg;
  localparam int unsigned CLK_PERIOD_NS      = 40;
  // sleep entry interval in clock cycles
  localparam int unsigned SLEEP_ENTRY_CYCLES = 2;
  // recovery time in ns, plain default
  localparam int unsigned SLEEP_RECOVERY_NS  = 100;
  localparam int unsigned RECOVERY_CYCLES_RAW =
    SLEEP_RECOVERY_NS / CLK_PERIOD_NS;
  localparam int unsigned RECOVERY_CYCLES    =
    (RECOVERY_CYCLES_RAW < 1) ? 1 : RECOVERY_CYCLES_RAW;
  localparam int unsigned CNT_W              = 8;
  localparam int unsigned ADDR_W             = 4;
  localparam int unsigned DATA_W             = 8;
  localparam int unsigned LANES              = 1;
  localparam int unsigned DEPTH              = 16;
  localparam logic [7:0]  ENTRY_CNT  = 8'(SLEEP_ENTRY_CYCLES);
  localparam logic [7:0]  RECOV_CNT  = 8'(RECOVERY_CYCLES);
  localparam logic [7:0]  ZERO_CNT   = 8'h00;
  localparam logic [7:0]  ONE_CNT    = 8'h01;
  localparam logic [7:0]  ZERO_DATA  = 8'h00;
  localparam logic [3:0]  ZERO_ADDR  = 4'h0;

  // sleep sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_NORMAL  = 4'b0001,
    ST_ENTRY   = 4'b0010,
    ST_SLEEP   = 4'b0100,
    ST_RECOVER = 4'b1000
  } sleep_state_type;
endpackage : sram_qualify_pkg

/* File: hdl/sram_qualify.sv */
// Purpose: cycle qualification and sleep sequencing of a flow-through sram
// Assumes: inputs synchronous to i_sys_clk; far side keeps its timing
// Notes:   small array stands in for the memory core;
//          status flags are registered copies of the next state
//
// Summary of operation
// - a cycle writes when global write is low or the qualifier is low with any lane low.
// - the part is enabled when a strobe is active and selects read low, high, low.
// - the combined strobe is active when either strobe is low.
// - asserting sleep passes through a no-access interval before sleep.
// - in sleep the part deselects itself regardless of selects and strobes.
// - in sleep the registers reload their own values so the free clock changes nothing.
// - in sleep all toggling inputs are ignored, no access is performed.
// - with strobes tied the part takes a new address every cycle.
`timescale 1ns/1ps
`default_nettype none
module sram_qualify (
  // clock, reset, enable
  input  wire logic                                  i_sys_clk,
  input  wire logic                                  i_nrst,
  input  wire logic                                  i_clk_en,
  // sleep control
  input  wire logic                                  i_sleep_request,
  // strobes and selects, active low except chip_select_high
  input  wire logic                                  i_controller_address_strobe_n,
  input  wire logic                                  i_processor_address_strobe_n,
  input  wire logic                                  i_chip_select_low_first_n,
  input  wire logic                                  i_chip_select_high,
  input  wire logic                                  i_chip_select_low_third_n,
  // write controls, active low
  input  wire logic                                  i_global_write_n,
  input  wire logic                                  i_write_qualifier_n,
  input  wire logic [sram_qualify_pkg::LANES-1:0]    i_byte_lane_write_n,
  // address and data
  input  wire logic [sram_qualify_pkg::ADDR_W-1:0]   i_addr,
  input  wire logic [sram_qualify_pkg::DATA_W-1:0]   i_wdata,
  // status and read data
  output logic                                       o_enabled,
  output logic                                       o_write_cycle,
  output logic                                       o_no_access,
  output logic                                       o_asleep,
  output logic [sram_qualify_pkg::DATA_W-1:0]        o_rdata
);

  typedef struct packed {
    sram_qualify_pkg::sleep_state_type           state;
    logic [sram_qualify_pkg::CNT_W-1:0]          cnt;
    logic                                        enabled;
    logic                                        write_cycle;
    logic                                        no_access;
    logic                                        asleep;
    logic [sram_qualify_pkg::DATA_W-1:0]         rdata;
  } regs_type;

  regs_type r;
  regs_type next_r;
  logic [sram_qualify_pkg::DATA_W-1:0] mem [sram_qualify_pkg::DEPTH];

  // combined strobe, active high when either strobe is low
  function automatic logic strobe_active(input logic c_n, input logic p_n);
    strobe_active = !(c_n && p_n);
  endfunction : strobe_active

  // chip enable pattern of the three selects: low, high, low
  function automatic logic select_match(input logic first_n,
                                        input logic high,
                                        input logic third_n);
    select_match = !first_n && high && !third_n;
  endfunction : select_match

  // write decode: global write, or qualifier with any lane low
  function automatic logic write_request(
    input logic                               global_n,
    input logic                               qual_n,
    input logic [sram_qualify_pkg::LANES-1:0] lanes_n);
    write_request = !global_n || (!qual_n && !(&lanes_n));
  endfunction : write_request

  // normal state test, shared by access gating and status flag
  function automatic logic is_normal(
    input sram_qualify_pkg::sleep_state_type s);
    is_normal = (s == sram_qualify_pkg::ST_NORMAL);
  endfunction : is_normal

  // interval counter in its last cycle
  function automatic logic count_done(
    input logic [sram_qualify_pkg::CNT_W-1:0] c);
    count_done = (c <= sram_qualify_pkg::ONE_CNT);
  endfunction : count_done

  // interval counter step
  function automatic logic [sram_qualify_pkg::CNT_W-1:0] count_down(
    input logic [sram_qualify_pkg::CNT_W-1:0] c);
    count_down = c - sram_qualify_pkg::ONE_CNT;
  endfunction : count_down

  logic any_address_strobe;
  logic sel_ok;
  logic wr_req;
  logic access_ok;

  // decode of strobes, selects and write controls
  always_comb
  begin
    any_address_strobe = strobe_active(i_controller_address_strobe_n,
                                       i_processor_address_strobe_n);
    sel_ok = select_match(i_chip_select_low_first_n, i_chip_select_high,
                          i_chip_select_low_third_n);
    wr_req = write_request(i_global_write_n, i_write_qualifier_n,
                           i_byte_lane_write_n);
    // accesses only in normal operation, tied strobes give one per cycle
    access_ok = is_normal(r.state)
                && !i_sleep_request && any_address_strobe && sel_ok;
  end

  // next state of the sleep sequencer and cycle flags
  always_comb
  begin
    next_r = r;
    next_r.enabled = access_ok;
    next_r.write_cycle = access_ok && wr_req;
    if (access_ok && !wr_req)
    begin
      next_r.rdata = mem[i_addr];
    end
    case (r.state)
      sram_qualify_pkg::ST_NORMAL:
      begin
        if (i_sleep_request)
        begin
          next_r.state = sram_qualify_pkg::ST_ENTRY;
          next_r.cnt = sram_qualify_pkg::ENTRY_CNT;
        end
      end
      sram_qualify_pkg::ST_ENTRY:
      begin
        // a withdrawn request still pays the recovery interval
        next_r.cnt = count_down(r.cnt);
        if (!i_sleep_request)
        begin
          next_r.state = sram_qualify_pkg::ST_RECOVER;
          next_r.cnt = sram_qualify_pkg::RECOV_CNT;
        end
        else if (count_done(r.cnt))
        begin
          next_r.state = sram_qualify_pkg::ST_SLEEP;
        end
      end
      sram_qualify_pkg::ST_SLEEP:
      begin
        // deselected, inputs ignored
        next_r.enabled = 1'b0;
        next_r.write_cycle = 1'b0;
        if (!i_sleep_request)
        begin
          next_r.state = sram_qualify_pkg::ST_RECOVER;
          next_r.cnt = sram_qualify_pkg::RECOV_CNT;
        end
      end
      sram_qualify_pkg::ST_RECOVER:
      begin
        // a new request during recovery goes back through entry
        next_r.cnt = count_down(r.cnt);
        if (i_sleep_request)
        begin
          next_r.state = sram_qualify_pkg::ST_ENTRY;
          next_r.cnt = sram_qualify_pkg::ENTRY_CNT;
        end
        else if (count_done(r.cnt))
        begin
          next_r.state = sram_qualify_pkg::ST_NORMAL;
          next_r.cnt = sram_qualify_pkg::ZERO_CNT;
        end
      end
      default:
      begin
        next_r.state = sram_qualify_pkg::ST_NORMAL;
        next_r.cnt = sram_qualify_pkg::ZERO_CNT;
      end
    endcase
    // status flags follow the next state so outputs come from flops
    next_r.no_access = !is_normal(next_r.state);
    next_r.asleep = (next_r.state == sram_qualify_pkg::ST_SLEEP);
  end

  // state register, frozen while asleep except for wake detection
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      r.state <= sram_qualify_pkg::ST_NORMAL;
      r.cnt <= sram_qualify_pkg::ZERO_CNT;
      r.enabled <= 1'b0;
      r.write_cycle <= 1'b0;
      r.rdata <= sram_qualify_pkg::ZERO_DATA;
      r.no_access <= 1'b0;
      r.asleep <= 1'b0;
    end
    else if (i_clk_en)
    begin
      r <= next_r;
    end
  end

  // array write, only from a qualified normal cycle
  always_ff @(posedge i_sys_clk)
  begin
    if (i_clk_en && access_ok && wr_req)
    begin
      mem[i_addr] <= i_wdata;
    end
  end

  // outputs straight from flops
  always_comb
  begin
    o_enabled = r.enabled;
    o_write_cycle = r.write_cycle;
    o_no_access = r.no_access;
    o_asleep = r.asleep;
    o_rdata = r.rdata;
  end

endmodule : sram_qualify
`default_nettype wire

/* File: testbench/sram_qualify_asserts.sv */
// Purpose: port checks of sram_qualify
// Assumes: one clock domain
// Notes:   bound to the design below
`timescale 1ns/1ps
`default_nettype none
module sram_qualify_asserts (
  // clock, reset, sleep
  input wire logic       i_sys_clk, i_nrst, i_clk_en, i_sleep_request,
  // strobes, selects, writes
  input wire logic       i_controller_address_strobe_n,
  input wire logic       i_processor_address_strobe_n,
  input wire logic       i_chip_select_low_first_n, i_chip_select_high,
  input wire logic       i_chip_select_low_third_n, i_global_write_n,
  input wire logic       i_write_qualifier_n,
  input wire logic [0:0] i_byte_lane_write_n,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  // status
  input wire logic       o_enabled, o_write_cycle, o_no_access, o_asleep,
  input wire logic [7:0] o_rdata
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  // qualified access and write decode
  wire acs = !i_controller_address_strobe_n | !i_processor_address_strobe_n;
  wire sel = !i_chip_select_low_first_n & i_chip_select_high
             & !i_chip_select_low_third_n;
  wire tk = i_clk_en & !o_no_access & !i_sleep_request & acs & sel;
  wire wr = !i_global_write_n | (!i_write_qualifier_n & !i_byte_lane_write_n);
  property p_en; tk |=> o_enabled; endproperty
  a_en: assert property (p_en) else $error("no enable");
  property p_noen; i_clk_en && !tk |=> !o_enabled; endproperty
  a_noen: assert property (p_noen) else $error("stray enable");
  property p_wr; tk && wr |=> o_write_cycle; endproperty
  a_wr: assert property (p_wr) else $error("write missed");
  property p_rd; tk && !wr |=> !o_write_cycle; endproperty
  a_rd: assert property (p_rd) else $error("false write");
  property p_in; i_clk_en && !o_no_access && i_sleep_request
    |=> o_no_access && !o_asleep; endproperty
  a_in: assert property (p_in) else $error("no entry gap");
  property p_zz; $rose(o_asleep) |-> $past(o_no_access, 2); endproperty
  a_zz: assert property (p_zz) else $error("early sleep");
  property p_gate; o_asleep && i_sleep_request
    |=> o_asleep && $stable(o_rdata); endproperty
  a_gate: assert property (p_gate) else $error("moved in sleep");
  property p_up; $fell(o_asleep) && !i_sleep_request
    ##1 !i_sleep_request |=> !o_no_access; endproperty
  a_up: assert property (p_up) else $error("no wake");
  // main scenarios
  cover property (tk && wr);
  cover property ($rose(o_asleep));
  cover property ($fell(o_no_access));
  cover property (!i_clk_en && o_enabled);
endmodule : sram_qualify_asserts
bind sram_qualify sram_qualify_asserts i_sram_qualify_asserts (.*);
`default_nettype wire

/* File: testbench/sram_ctrl_model.sv */
// Purpose: controller side driving strobes, selects and writes
// Assumes: tasks called just after a rising edge
// Notes:   held lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module sram_ctrl_model (
  // strobes {controller, processor}, selects, writes {global, qual, lane}
  output logic [1:0] o_strobe_n,
  output logic [2:0] o_sel,
  output logic [2:0] o_wr,
  // address and data
  output logic [3:0] o_addr,
  output logic [7:0] o_wdata
);
  // no access: strobes and writes high
  task automatic idle();
    o_strobe_n = 2'h3;
    o_wr = 3'h7;
    o_addr = ~o_addr;
    o_wdata = ~o_wdata;
  endtask : idle
  // one access, held until the next rising edge
  task automatic access(input logic [7:0] c, logic [3:0] a, logic [7:0] d);
    {o_strobe_n, o_sel, o_wr} = c;
    o_addr = a;
    o_wdata = d;
  endtask : access
  // start idle
  initial
  begin
    {o_sel, o_addr, o_wdata} = 15'h1000;
    idle();
  end
endmodule : sram_ctrl_model
`default_nettype wire

/* File: testbench/tb.sv */
// Purpose: self-checking bench of sram_qualify
// Assumes: far side modelled by sram_ctrl_model
// Notes:   notes queued by driver, checked at falling edge
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       clk, nrst, slp, en, wc, na, asl;
  logic [1:0] sn;
  logic [2:0] sl, wr;
  logic [3:0] a;
  logic [7:0] d, rd;
  logic [7:0] mem [16];
  logic       ce;
  logic [12:0] q [$];
  logic [12:0] n;
  logic [12:0] last;
  int         fails, tests_run;
  // free running clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  sram_ctrl_model i_sram_ctrl_model (.o_strobe_n(sn), .o_sel(sl),
    .o_wr(wr), .o_addr(a), .o_wdata(d));
  sram_qualify i_sram_qualify (.i_sys_clk(clk), .i_nrst(nrst),
    .i_clk_en(ce), .i_sleep_request(slp),
    .i_controller_address_strobe_n(sn[1]),
    .i_processor_address_strobe_n(sn[0]),
    .i_chip_select_low_first_n(sl[2]), .i_chip_select_high(sl[1]),
    .i_chip_select_low_third_n(sl[0]), .i_global_write_n(wr[2]),
    .i_write_qualifier_n(wr[1]), .i_byte_lane_write_n(wr[0]),
    .i_addr(a), .i_wdata(d), .o_enabled(en), .o_write_cycle(wc),
    .o_no_access(na), .o_asleep(asl), .o_rdata(rd));
  // verdict
  task automatic complete_run();
    if (fails == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run
  // status flag compare
  task automatic cmp_flag(string s, logic e, logic g);
    tests_run++;
    if (e !== g)
    begin
      fails++;
      $display("wrong value %s exp %h got %h", s, e, g);
    end
  endtask : cmp_flag
  // read data compare
  task automatic cmp_data(string s, logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (e !== g)
    begin
      fails++;
      $display("wrong value %s exp %h got %h", s, e, g);
    end
  endtask : cmp_data
  // one access cycle; off marks the part as asleep
  task automatic go(logic [7:0] c, logic [3:0] aa, logic [7:0] dd, logic off);
    logic e, w;
    e = ce && !off && c[7:6] != 2'h3 && c[5:3] == 3'h2;
    w = e && (!c[2] || !c[1] && !c[0]);
    i_sram_ctrl_model.access(c, aa, dd);
    @(posedge clk) #1;
    // a frozen cycle keeps the previous outputs
    if (ce) last = {e, w, e && !w, off, off, mem[aa]};
    q.push_back(last);
    if (w) mem[aa] = dd;
  endtask : go
  task automatic rest(int k);
    i_sram_ctrl_model.idle();
    repeat (k) @(posedge clk);
    #1;
  endtask : rest
  // result checker
  always @(negedge clk)
    if (q.size() > 0)
    begin
      n = q.pop_front();
      cmp_flag("enabled", n[12], en);
      cmp_flag("write", n[11], wc);
      cmp_flag("asleep", n[9], asl);
      cmp_flag("no_access", n[8], na);
      if (n[10]) cmp_data("rdata", n[7:0], rd);
    end
  // fill, random back to back mix, sleep, read back
  initial
  begin
    {nrst, slp, ce} = 3'h1;
    last = 13'h0000;
    void'($urandom(32'ha652));
    repeat (5) @(posedge clk);
    #1 nrst = 1'b1;
    for (int i = 0; i < 16; i++) go(8'h53, 4'(i), 8'($urandom), 1'b0);
    // random mix, clock enable dropping now and then
    repeat (60)
    begin
      ce = ($urandom % 4) != 0;
      go({2'($urandom), $urandom % 2 ? 3'h2 : 3'($urandom),
        3'($urandom)}, 4'($urandom), 8'($urandom), 1'b0);
    end
    // non-burst tie-off: controller strobe and first select low
    repeat (40)
    begin
      ce = ($urandom % 4) != 0;
      go({1'b0, 1'($urandom), 1'b0, 2'($urandom), 3'($urandom)},
        4'($urandom), 8'($urandom), 1'b0);
    end
    ce = 1'b1;
    rest(1);
    slp = 1'b1;
    rest(4);
    repeat (6) go(8'($urandom), 4'($urandom), 8'($urandom), 1'b1);
    slp = 1'b0;
    rest(4);
    for (int i = 0; i < 16; i++) go(8'h97, 4'(i), 8'h00, 1'b0);
    // request withdrawn in entry, raised again in recovery, withdrawn again in entry
    slp = 1'b1;
    rest(1);
    slp = 1'b0;
    rest(1);
    slp = 1'b1;
    rest(1);
    slp = 1'b0;
    rest(5);
    for (int i = 0; i < 16; i++) go(8'h97, 4'(i), 8'h00, 1'b0);
    rest(2);
    complete_run();
  end
  // hang guard
  initial
  begin
    #100us;
    fails++;
    complete_run();
  end
endmodule : tb
`default_nettype wire
